// ===== inc/nrch_regs.svh
// constants for the node reset command handler
`ifndef NRCH_REGS_SVH
`define NRCH_REGS_SVH

`define NRCH_CMD_CAN_ID     11'h000
`define NRCH_CMD_DLC        4'h2
`define NRCH_NODE_BCAST     8'h00
`define NRCH_NODE_MAX       8'h7F
`define NRCH_CMD_FULL_RST   8'h81
`define NRCH_CMD_LIM_RST    8'h82
`define NRCH_BOOTUP_BASE    11'h700
`define NRCH_MSG_COUNT      4

`endif

// ===== inc/nrch_pkg.sv
// types shared by the node reset command handler
package nrch_pkg;

    // received CAN frame as handed over by the controller
    typedef struct packed {
        logic        valid;
        logic [10:0] id;
        logic [3:0]  dlc;
        logic [7:0]  byte0;
        logic [7:0]  byte1;
    } nrch_rx_frame_type;

    // parameters of one CAN message
    typedef struct packed {
        logic [10:0] can_id;
        logic [15:0] event_timer;
        logic [15:0] inhibit_time;
    } nrch_msg_param_type;

    typedef enum logic [4:0] {
        NRCH_ST_RUN     = 5'b00001,
        NRCH_ST_LOAD_IO = 5'b00010,
        NRCH_ST_LOAD_MS = 5'b00100,
        NRCH_ST_BOOTUP  = 5'b01000,
        NRCH_ST_WAIT_TX = 5'b10000
    } nrch_state_type;

endpackage : nrch_pkg

// ===== logic/nrch_handler.sv
// node reset command handler: full and limited reset of a CAN I/O node
//
// Behaviour
// RULE_01: state commands come on identifier 0x000, byte 0 command, byte 1 node.
// RULE_02: node 0x00 is broadcast, own number 0x01-0x7F executes, others ignored.
// RULE_03: command 0x81 requests a full reset of every function.
// RULE_04: command 0x82 requests a limited reset of CAN communication only.
// RULE_05: no transmitting or responding on CAN while reset initialisation runs.
// RULE_06: on completing initialisation, transmit the startup announcement frame.
// RULE_07: after announcement, enter the operational network state.
// RULE_08: full reset loads stored configuration if valid, else defaults.
// RULE_09: full reset drives all digital and analog outputs to configured defaults.
// RULE_10: limited reset keeps all I/O configuration unchanged.
// RULE_11: limited reset leaves present output values unchanged.
// RULE_12: limited reset reloads identifier, event timer, inhibit time per message.
// RULE_13: limited reset takes message parameters from valid store, else defaults.
// RULE_14: unknown command codes are ignored with no effect.
`timescale 1ns/1ps
`include "nrch_regs.svh"

module nrch_handler #(
    parameter int MSG_N   = `NRCH_MSG_COUNT,
    parameter int DOUT_W  = 8,
    parameter int AOUT_W  = 16,
    parameter int AOUT_N  = 2,
    parameter int IOCFG_W = 32
) (
    input  wire logic                                  ref_clk,
    input  wire logic                                  rst,
    input  wire logic [6:0]                            node_id,
    input  wire nrch_pkg::nrch_rx_frame_type           rx_frame,
    input  wire logic                                  store_valid,
    input  wire logic [IOCFG_W-1:0]                    store_io_cfg,
    input  wire logic [IOCFG_W-1:0]                    dflt_io_cfg,
    input  wire logic [DOUT_W-1:0]                     store_dout_dflt,
    input  wire logic [DOUT_W-1:0]                     dflt_dout_dflt,
    input  wire logic [AOUT_N*AOUT_W-1:0]              store_aout_dflt,
    input  wire logic [AOUT_N*AOUT_W-1:0]              dflt_aout_dflt,
    input  wire nrch_pkg::nrch_msg_param_type [MSG_N-1:0] store_msg,
    input  wire nrch_pkg::nrch_msg_param_type [MSG_N-1:0] dflt_msg,
    input  wire logic                                  app_dout_we,
    input  wire logic [DOUT_W-1:0]                     app_dout,
    input  wire logic                                  app_aout_we,
    input  wire logic [AOUT_N*AOUT_W-1:0]              app_aout,
    input  wire logic                                  tx_done,
    output logic                                       tx_req,
    output logic [10:0]                                tx_id,
    output logic                                       can_quiet,
    output logic                                       operational,
    output logic                                       init_busy,
    output logic [IOCFG_W-1:0]                         io_cfg,
    output logic [DOUT_W-1:0]                          dout,
    output logic [AOUT_N*AOUT_W-1:0]                   aout,
    output nrch_pkg::nrch_msg_param_type [MSG_N-1:0]   msg_param
);
    import nrch_pkg::*;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    // a node number of zero would alias the broadcast address; the
    // configuration is expected to keep node_id within 01 to 7F
    function automatic logic node_hit(input logic [7:0] n, input logic [6:0] own);
        node_hit = (n == `NRCH_NODE_BCAST) || (n == {1'b0, own}); // [RULE_02]
    endfunction : node_hit

    logic cmd_frame;
    logic hit;
    logic do_full;
    logic do_lim;

    // frames of the wrong length are dropped, never padded or cut
    always_comb begin
        cmd_frame = rx_frame.valid && rx_frame.id == `NRCH_CMD_CAN_ID
                    && rx_frame.dlc == `NRCH_CMD_DLC;                // [RULE_01]
        hit       = cmd_frame && node_hit(rx_frame.byte1, node_id);  // [RULE_02]
        do_full   = hit && rx_frame.byte0 == `NRCH_CMD_FULL_RST;      // [RULE_03]
        do_lim    = hit && rx_frame.byte0 == `NRCH_CMD_LIM_RST;       // [RULE_04]
        // any other code falls through with no effect [RULE_14]
    end

    // ----------------------------------------------------------------
    // reset sequencer and data
    // ----------------------------------------------------------------
    // walk: LOAD_IO (full reset only), LOAD_MS, BOOTUP, WAIT_TX, back to RUN;
    // commands outside RUN are dropped, so only one reset runs at a time
    nrch_state_type                    state_r, state_nxt;
    logic                              tx_req_r, tx_req_nxt;
    logic                              quiet_r, quiet_nxt;
    logic                              oper_r, oper_nxt;
    logic [IOCFG_W-1:0]                io_cfg_r, io_cfg_nxt;
    logic [DOUT_W-1:0]                 dout_r, dout_nxt;
    logic [AOUT_N*AOUT_W-1:0]          aout_r, aout_nxt;
    nrch_msg_param_type [MSG_N-1:0]    msg_r, msg_nxt;

    // defaults hold every register; the transmit request is rebuilt each cycle
    always_comb begin
        state_nxt  = state_r;
        tx_req_nxt = 1'b0;
        quiet_nxt  = quiet_r;
        oper_nxt   = oper_r;
        io_cfg_nxt = io_cfg_r;
        dout_nxt   = dout_r;
        aout_nxt   = aout_r;
        msg_nxt    = msg_r;
        case (state_r)
            NRCH_ST_RUN: begin
                // application writes land only here, so loaded defaults survive init
                if (app_dout_we) begin
                    dout_nxt = app_dout;
                end
                if (app_aout_we) begin
                    aout_nxt = app_aout;
                end
                if (do_full) begin
                    quiet_nxt = 1'b1;                                // [RULE_05]
                    state_nxt = NRCH_ST_LOAD_IO;
                end else if (do_lim) begin
                    // io config and outputs deliberately untouched [RULE_10] [RULE_11]
                    quiet_nxt = 1'b1;                                // [RULE_05]
                    state_nxt = NRCH_ST_LOAD_MS;
                end
            end
            NRCH_ST_LOAD_IO: begin
                // full reset only
                // outputs take their configured defaults together with the configuration
                if (store_valid) begin                               // [RULE_08]
                    io_cfg_nxt = store_io_cfg;
                    dout_nxt   = store_dout_dflt;                    // [RULE_09]
                    aout_nxt   = store_aout_dflt;
                end else begin
                    io_cfg_nxt = dflt_io_cfg;
                    dout_nxt   = dflt_dout_dflt;                     // [RULE_09]
                    aout_nxt   = dflt_aout_dflt;
                end
                state_nxt = NRCH_ST_LOAD_MS;
            end
            NRCH_ST_LOAD_MS: begin
                // a limited reset enters here directly and never touches io_cfg, dout or aout
                msg_nxt   = store_valid ? store_msg : dflt_msg;      // [RULE_12] [RULE_13] [RULE_08]
                state_nxt = NRCH_ST_BOOTUP;
            end
            NRCH_ST_BOOTUP: begin
                // quiet ends on the edge the request rises: no gap, no overlap
                quiet_nxt  = 1'b0;
                tx_req_nxt = 1'b1;                                   // [RULE_06]
                state_nxt  = NRCH_ST_WAIT_TX;
            end
            NRCH_ST_WAIT_TX: begin
                // no retry limit: a controller that never reports done stalls here
                tx_req_nxt = ~tx_done;
                if (tx_done) begin
                    oper_nxt  = 1'b1;                                // [RULE_07]
                    state_nxt = NRCH_ST_RUN;
                end
            end
            default: begin
                // unreachable with one-hot codes; recovers to RUN after a bit upset
                state_nxt = NRCH_ST_RUN;
            end
        endcase
    end

    // boot-time values come up through the full reset path after power-on
    // so the power-on walk announces the node just like a full reset command
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r  <= NRCH_ST_LOAD_IO;
            tx_req_r <= 1'b0;
            quiet_r  <= 1'b1;
            oper_r   <= 1'b0;
            io_cfg_r <= '0;
            dout_r   <= '0;
            aout_r   <= '0;
            msg_r    <= '0;
        end else begin
            state_r  <= state_nxt;
            tx_req_r <= tx_req_nxt;
            quiet_r  <= quiet_nxt;
            oper_r   <= oper_nxt;
            io_cfg_r <= io_cfg_nxt;
            dout_r   <= dout_nxt;
            aout_r   <= aout_nxt;
            msg_r    <= msg_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // identifier follows node_id every cycle, so a renumbered node
    // announces itself under its new number
    logic        busy_r;
    logic [10:0] tx_id_r;
    logic        busy_nxt;
    logic [10:0] tx_id_nxt;

    always_comb begin
        // busy follows the next state so it rises on the edge the command is taken
        busy_nxt  = state_nxt != NRCH_ST_RUN;
        tx_id_nxt = `NRCH_BOOTUP_BASE + {4'h0, node_id};            // [RULE_06]
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_r  <= 1'b1;
            tx_id_r <= `NRCH_BOOTUP_BASE;
        end else begin
            busy_r  <= busy_nxt;
            tx_id_r <= tx_id_nxt;
        end
    end

    // every port is a plain copy of a register
    assign tx_req      = tx_req_r;
    assign tx_id       = tx_id_r;
    assign can_quiet   = quiet_r;
    assign operational = oper_r;
    assign init_busy   = busy_r;
    assign io_cfg      = io_cfg_r;
    assign dout        = dout_r;
    assign aout        = aout_r;
    assign msg_param   = msg_r;

endmodule : nrch_handler

// ===== verification/nrch_handler_assertions.sv
// assertions on the node reset command handler ports
`timescale 1ns/1ps
module nrch_handler_assertions import nrch_pkg::*; #(parameter int DOUT_W = 8) (
    input wire logic                        ref_clk,
    input wire logic                        rst,
    input wire logic [6:0]                  node_id,
    input wire nrch_pkg::nrch_rx_frame_type rx_frame,
    input wire logic                        tx_req,
    input wire logic [10:0]                 tx_id,
    input wire logic                        can_quiet,
    input wire logic                        operational,
    input wire logic                        init_busy,
    input wire logic [DOUT_W-1:0]           dout
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic to_me = rx_frame.byte1 == 8'h00 || rx_frame.byte1 == {1'b0, node_id};
    wire logic addr_ok = rx_frame.id == 11'h000 && rx_frame.dlc == 4'h2 && to_me;
    wire logic ok = rx_frame.valid && !init_busy && addr_ok;
    full_seq_a: assert property (ok && rx_frame.byte0 == 8'h81 |-> ##1 (can_quiet && init_busy) ##3 $rose(tx_req))
        else $error("full reset sequence off");
    lim_seq_a: assert property (ok && rx_frame.byte0 == 8'h82 |-> ##1 can_quiet ##2 $rose(tx_req))
        else $error("limited reset sequence off");
    lim_hold_a: assert property (ok && rx_frame.byte0 == 8'h82 |-> ##2 $stable(dout) [*2])
        else $error("outputs moved in limited reset");
    quiet_tx_a: assert property (can_quiet |-> !tx_req)
        else $error("transmit while quiet");
    oper_entry_a: assert property ($fell(tx_req) |-> operational && !init_busy)
        else $error("not operational after bootup");
    boot_id_a: assert property (tx_req |-> tx_id == 11'h700 + {4'h0, node_id})
        else $error("bad bootup identifier");
    bad_code_a: assert property (ok && rx_frame.byte0 != 8'h81 && rx_frame.byte0 != 8'h82 |=> !init_busy)
        else $error("unknown code acted on");
    bad_addr_a: assert property (rx_frame.valid && !init_busy && !addr_ok |=> !init_busy)
        else $error("foreign frame acted on");
endmodule : nrch_handler_assertions

bind nrch_handler nrch_handler_assertions #(.DOUT_W(DOUT_W)) u_chk (.ref_clk, .rst, .node_id, .rx_frame,
    .tx_req, .tx_id, .can_quiet, .operational, .init_busy, .dout);

// ===== verification/nrch_can_master.sv
// network master and CAN controller stand-in for the reset command handler
`timescale 1ns/1ps
module nrch_can_master import nrch_pkg::*; (
    input wire logic                   ref_clk,
    input wire logic                   tx_req,
    output nrch_pkg::nrch_rx_frame_type rx_frame,
    output logic                       tx_done
);
    int lat = 1;
    initial begin
        rx_frame = '0;
        tx_done = 1'b0;
    end
    task automatic send(input logic [10:0] id, input logic [7:0] code, input logic [7:0] node, input logic [3:0] dlc);
        @(posedge ref_clk);
        #1 rx_frame = '{1'b1, id, dlc, code, node};
        @(posedge ref_clk);
        // stale frame fields are inverted so nothing can latch them by luck
        #1 rx_frame = {1'b0, ~rx_frame[30:0]};
    endtask : send
    always begin
        @(posedge ref_clk iff tx_req === 1'b1);
        repeat (lat) @(posedge ref_clk);
        #1 tx_done = 1'b1;
        @(posedge ref_clk);
        #1 tx_done = 1'b0;
        wait (tx_req !== 1'b1);
    end
endmodule : nrch_can_master

// ===== verification/nrch_handler_test.sv
// self-checking bench for the node reset command handler
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
    $display("unexpected %s exp %h seen %h", n, e, s); end end
module nrch_handler_test;
    import nrch_pkg::*;
    localparam int W = 244;
    logic ref_clk = 1'b0, rst = 1'b1, store_valid = 1'b0, app_dout_we = 1'b0, app_aout_we = 1'b0;
    logic tx_req, tx_done, can_quiet, operational, init_busy;
    logic [6:0] node_id = 7'h2A;
    logic [31:0] store_io_cfg, dflt_io_cfg, store_aout_dflt, dflt_aout_dflt, app_aout, io_cfg, aout;
    logic [7:0] store_dout_dflt, dflt_dout_dflt, app_dout, dout;
    logic [10:0] tx_id;
    logic [W-1:0] cur, seen_exp;
    logic [W-1:0] note_q[$];
    logic [30:0] skip_tab[6] = '{{11'h000, 8'h01, 8'h00, 4'h2}, {11'h000, 8'h80, 8'h2A, 4'h2},
        {11'h000, 8'h81, 8'h2B, 4'h2}, {11'h000, 8'h82, 8'hAA, 4'h2}, {11'h000, 8'h81, 8'h00, 4'h3},
        {11'h001, 8'h82, 8'h00, 4'h2}};
    int err_total = 0, samples_checked = 0, seed = 50300, i;
    nrch_rx_frame_type rx_frame;
    nrch_msg_param_type [3:0] store_msg, dflt_msg, msg_param;

    nrch_handler u_dut (.ref_clk, .rst, .node_id, .rx_frame, .store_valid, .store_io_cfg, .dflt_io_cfg,
        .store_dout_dflt, .dflt_dout_dflt, .store_aout_dflt, .dflt_aout_dflt, .store_msg, .dflt_msg,
        .app_dout_we, .app_dout, .app_aout_we, .app_aout, .tx_done, .tx_req, .tx_id, .can_quiet,
        .operational, .init_busy, .io_cfg, .dout, .aout, .msg_param);
    nrch_can_master u_master (.ref_clk, .tx_req, .rx_frame, .tx_done);
    initial forever #2 ref_clk = ~ref_clk;

    task automatic rnd;
        {store_io_cfg, dflt_io_cfg} = {$random(seed), $random(seed)};
        {store_aout_dflt, dflt_aout_dflt} = {$random(seed), $random(seed)};
        {store_dout_dflt, dflt_dout_dflt} = 16'($random(seed));
        for (int k = 0; k < 4; k++) begin
            store_msg[k] = 43'({$random(seed), $random(seed)});
            dflt_msg[k] = 43'({$random(seed), $random(seed)});
        end
    endtask : rnd
    task automatic settle(input string n);
        for (int k = 0; k < 60 && (init_busy !== 1'b0 || tx_req !== 1'b0); k++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK("operational", 1'b1, operational)
        `CHK("init finished", 1'b0, init_busy)
        `CHK("request cleared", 1'b0, tx_req)
        $display("test %s done", n);
    endtask : settle
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // every bootup frame is matched against the oldest expected load
    initial forever begin
        @(posedge tx_req);
        #1 seen_exp = note_q.size() > 0 ? note_q.pop_front() : 'x;
        `CHK("loaded values", seen_exp, {io_cfg, dout, aout, msg_param})
        `CHK("bootup id", 11'h700 + {4'h0, node_id}, tx_id)
        `CHK("quiet at bootup", 1'b0, can_quiet)
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_total++;
        end_of_test();
    end
    initial begin
        {app_dout, app_aout} = '0;
        rnd();
        cur = {dflt_io_cfg, dflt_dout_dflt, dflt_aout_dflt, dflt_msg};
        note_q.push_back(cur);
        repeat (5) @(posedge ref_clk);
        #1 rst = 1'b0;
        settle("power-up");
        store_valid = 1'b1;
        rnd();
        cur = {store_io_cfg, store_dout_dflt, store_aout_dflt, store_msg};
        note_q.push_back(cur);
        u_master.send(11'h000, 8'h81, 8'h00, 4'h2);
        settle("full broadcast");
        {app_dout, app_aout} = 40'({$random(seed), $random(seed)});
        {app_dout_we, app_aout_we} = 2'h3;
        @(posedge ref_clk);
        #1 {app_dout_we, app_aout_we} = 2'h0;
        store_valid = 1'b0;
        rnd();
        u_master.lat = 6;
        cur = {cur[W-1:W-32], app_dout, app_aout, dflt_msg};
        note_q.push_back(cur);
        u_master.send(11'h000, 8'h82, {1'b0, node_id}, 4'h2);
        settle("limited own node");
        store_valid = 1'b1;
        rnd();
        cur = {cur[W-1:W-72], store_msg};
        note_q.push_back(cur);
        u_master.send(11'h000, 8'h82, 8'h00, 4'h2);
        settle("limited broadcast");
        for (i = 0; i < 6; i++) begin
            u_master.send(skip_tab[i][30:20], skip_tab[i][19:12], skip_tab[i][11:4], skip_tab[i][3:0]);
            repeat (4) @(posedge ref_clk);
            #1 `CHK("held state", cur, {io_cfg, dout, aout, msg_param})
        end
        $display("test ignored frames done");
        `CHK("notes left", 0, note_q.size())
        end_of_test();
    end
endmodule : nrch_handler_test
